// File: fslr_pkg.sv
// Package for the flash security lockout recovery block
package fslr_pkg;
  localparam logic [15:0] SEC_ADDR = 16'h1ff7;
  localparam logic [15:0] SEC_LOCKED = 16'h0002;
  localparam logic [15:0] SEC_OPEN = 16'h0000;
  localparam int IR_W = 4;
  localparam int DIV_W = 7;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_RECOVER = 4'h8;
  localparam logic [3:0] IR_DEBUG = 4'h7;
  localparam logic [3:0] IR_RESET_VAL = 4'h2;
  localparam logic [31:0] ID_RESET_VAL = 32'h0000_0001;
  localparam logic [6:0] DIV_RESET_VAL = 7'h00;
  // TAP controller states
  typedef enum logic [3:0] {
    FSLR_TLR = 4'h0, FSLR_RTI = 4'h1, FSLR_SDS = 4'h2, FSLR_CDR = 4'h3,
    FSLR_SDR = 4'h4, FSLR_E1D = 4'h5, FSLR_PDR = 4'h6, FSLR_E2D = 4'h7,
    FSLR_UDR = 4'h8, FSLR_SIS = 4'h9, FSLR_CIR = 4'ha, FSLR_SIR = 4'hb,
    FSLR_E1I = 4'hc, FSLR_PIR = 4'hd, FSLR_E2I = 4'he, FSLR_UIR = 4'hf
  } fslr_tap_e;
  typedef enum logic [1:0] {
    FSLR_IDLE = 2'b00, FSLR_ERASE = 2'b01, FSLR_DONE = 2'b10
  } fslr_rec_e;
endpackage : fslr_pkg

// File: fslr_tap.sv
// IEEE 1149.1 TAP state machine
`timescale 1ns/1ps
`default_nettype none
module fslr_tap (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic tck_rise,
  input wire logic tms,
  output var fslr_pkg::fslr_tap_e state
);
  fslr_pkg::fslr_tap_e state_r;
  fslr_pkg::fslr_tap_e state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    if (tck_rise)
    begin
      case (state_r)
        fslr_pkg::FSLR_TLR: state_nxt = tms ? fslr_pkg::FSLR_TLR : fslr_pkg::FSLR_RTI;
        fslr_pkg::FSLR_RTI: state_nxt = tms ? fslr_pkg::FSLR_SDS : fslr_pkg::FSLR_RTI;
        fslr_pkg::FSLR_SDS: state_nxt = tms ? fslr_pkg::FSLR_SIS : fslr_pkg::FSLR_CDR;
        fslr_pkg::FSLR_CDR: state_nxt = tms ? fslr_pkg::FSLR_E1D : fslr_pkg::FSLR_SDR;
        fslr_pkg::FSLR_SDR: state_nxt = tms ? fslr_pkg::FSLR_E1D : fslr_pkg::FSLR_SDR;
        fslr_pkg::FSLR_E1D: state_nxt = tms ? fslr_pkg::FSLR_UDR : fslr_pkg::FSLR_PDR;
        fslr_pkg::FSLR_PDR: state_nxt = tms ? fslr_pkg::FSLR_E2D : fslr_pkg::FSLR_PDR;
        fslr_pkg::FSLR_E2D: state_nxt = tms ? fslr_pkg::FSLR_UDR : fslr_pkg::FSLR_SDR;
        fslr_pkg::FSLR_UDR: state_nxt = tms ? fslr_pkg::FSLR_SDS : fslr_pkg::FSLR_RTI;
        fslr_pkg::FSLR_SIS: state_nxt = tms ? fslr_pkg::FSLR_TLR : fslr_pkg::FSLR_CIR;
        fslr_pkg::FSLR_CIR: state_nxt = tms ? fslr_pkg::FSLR_E1I : fslr_pkg::FSLR_SIR;
        fslr_pkg::FSLR_SIR: state_nxt = tms ? fslr_pkg::FSLR_E1I : fslr_pkg::FSLR_SIR;
        fslr_pkg::FSLR_E1I: state_nxt = tms ? fslr_pkg::FSLR_UIR : fslr_pkg::FSLR_PIR;
        fslr_pkg::FSLR_PIR: state_nxt = tms ? fslr_pkg::FSLR_E2I : fslr_pkg::FSLR_PIR;
        fslr_pkg::FSLR_E2I: state_nxt = tms ? fslr_pkg::FSLR_UIR : fslr_pkg::FSLR_SIR;
        fslr_pkg::FSLR_UIR: state_nxt = tms ? fslr_pkg::FSLR_SDS : fslr_pkg::FSLR_RTI;
        default: state_nxt = fslr_pkg::FSLR_TLR;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      state_r <= fslr_pkg::FSLR_TLR;
    else if (ce)
      state_r <= state_nxt;
  end

  assign state = state_r;
endmodule : fslr_tap
`default_nettype wire

// File: fslr_top.sv
// Flash security interlock and JTAG lockout recovery
`timescale 1ns/1ps
`default_nettype none
module fslr_top #(
  parameter int ID_W = 32,
  parameter logic [31:0] ID_CODE = 32'h1000_0001 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [15:0] sec_word,
  input wire logic dbg_flash_req,
  output logic dbg_flash_grant,
  output logic dbg_enable,
  output logic secured,
  output logic [6:0] erase_div,
  output logic erase_start,
  input wire logic erase_done,
  output logic erase_busy,
  input wire logic boundary_scan_tdo,
  output logic boundary_scan_sel,
  output logic debug_sel
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] tck_s_r, tck_s_nxt;
  logic [1:0] tms_s_r, tms_s_nxt, tdi_s_r, tdi_s_nxt;
  logic tck_rise, tck_fall;
  fslr_pkg::fslr_tap_e tap_st;

  always_comb
  begin
    tck_s_nxt = {tck_s_r[1:0], tck};
    tms_s_nxt = {tms_s_r[0], tms};
    tdi_s_nxt = {tdi_s_r[0], tdi};
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      tck_s_r <= 3'h0;
      tms_s_r <= 2'h3;
      tdi_s_r <= 2'h0;
    end
    else if (ce)
    begin
      tck_s_r <= tck_s_nxt;
      tms_s_r <= tms_s_nxt;
      tdi_s_r <= tdi_s_nxt;
    end
  end

  assign tck_rise = tck_s_r[1] & ~tck_s_r[2];
  assign tck_fall = ~tck_s_r[1] & tck_s_r[2];

  fslr_tap u_tap (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .tck_rise(tck_rise),
    .tms(tms_s_r[1]),
    .state(tap_st)
  );

  ////////////////////////////////////////////////////////////////////////
  // Instruction and data registers
  logic [3:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
  logic [31:0] dr_sh_r, dr_sh_nxt;
  logic [6:0] div_r, div_nxt;
  logic div_upd_r, div_upd_nxt;
  logic tdo_r, tdo_nxt, oe_r, oe_nxt;
  logic sec_r, sec_nxt, cap_r, cap_nxt;
  fslr_pkg::fslr_rec_e rec_r, rec_nxt;
  logic start_r, start_nxt;

  always_comb
  begin
    ir_sh_nxt = ir_sh_r;
    ir_nxt = ir_r;
    dr_sh_nxt = dr_sh_r;
    div_nxt = div_r;
    div_upd_nxt = div_upd_r;
    tdo_nxt = tdo_r;
    oe_nxt = oe_r;
    if (tck_rise)
    begin
      case (tap_st)
        fslr_pkg::FSLR_TLR:
        begin
          ir_nxt = fslr_pkg::IR_RESET_VAL;
          div_upd_nxt = 1'b0;
        end
        fslr_pkg::FSLR_CIR: ir_sh_nxt = 4'h1;
        fslr_pkg::FSLR_SIR: ir_sh_nxt = {tdi_s_r[1], ir_sh_r[3:1]};
        fslr_pkg::FSLR_UIR:
        begin
          ir_nxt = ir_sh_r;
          div_upd_nxt = 1'b0;
        end
        fslr_pkg::FSLR_CDR:
        begin
          if (ir_r == fslr_pkg::IR_IDCODE)
            dr_sh_nxt = ID_CODE;
          else if (ir_r == fslr_pkg::IR_RECOVER)
            dr_sh_nxt = {25'h0, div_r};
          else
            dr_sh_nxt = 32'h0;
        end
        fslr_pkg::FSLR_SDR:
        begin
          if (ir_r == fslr_pkg::IR_RECOVER)
            dr_sh_nxt = {25'h0, tdi_s_r[1], dr_sh_r[6:1]};
          else if (ir_r == fslr_pkg::IR_IDCODE)
            dr_sh_nxt = {tdi_s_r[1], dr_sh_r[31:1]};
          else
            dr_sh_nxt = {31'h0, tdi_s_r[1]};
        end
        fslr_pkg::FSLR_UDR:
        begin
          if (ir_r == fslr_pkg::IR_RECOVER)
          begin
            div_nxt = dr_sh_r[6:0];
            div_upd_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (tck_fall)
    begin
      oe_nxt = (tap_st == fslr_pkg::FSLR_SDR) || (tap_st == fslr_pkg::FSLR_SIR);
      if (tap_st == fslr_pkg::FSLR_SIR)
        tdo_nxt = ir_sh_r[0];
      else if (ir_r == fslr_pkg::IR_DEBUG || ir_r == fslr_pkg::IR_BYPASS)
        tdo_nxt = (ir_r == fslr_pkg::IR_DEBUG) ? boundary_scan_tdo : dr_sh_r[0];
      else
        tdo_nxt = dr_sh_r[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Security latch and recovery sequence
  always_comb
  begin
    cap_nxt = 1'b1;
    sec_nxt = sec_r;
    if (!cap_r)
      sec_nxt = (sec_word == fslr_pkg::SEC_LOCKED);
    rec_nxt = rec_r;
    start_nxt = 1'b0;
    case (rec_r)
      fslr_pkg::FSLR_IDLE:
      begin
        // erase starts on entering idle
        // Divider update and idle entry fall on the same tck edge
        if (tck_rise && div_upd_nxt && ir_r == fslr_pkg::IR_RECOVER
            && tap_st == fslr_pkg::FSLR_UDR && !tms_s_r[1])
        begin
          rec_nxt = fslr_pkg::FSLR_ERASE;
          start_nxt = 1'b1;
        end
      end
      fslr_pkg::FSLR_ERASE:
        if (erase_done)
          rec_nxt = fslr_pkg::FSLR_DONE;
      fslr_pkg::FSLR_DONE: rec_nxt = fslr_pkg::FSLR_DONE;
      default: rec_nxt = fslr_pkg::FSLR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ir_sh_r <= 4'h0;
      ir_r <= fslr_pkg::IR_RESET_VAL;
      dr_sh_r <= 32'h0;
      div_r <= fslr_pkg::DIV_RESET_VAL;
      div_upd_r <= 1'b0;
      tdo_r <= 1'b0;
      oe_r <= 1'b0;
      // secured until the word is read
      sec_r <= 1'b1;
      cap_r <= 1'b0;
      rec_r <= fslr_pkg::FSLR_IDLE;
      start_r <= 1'b0;
    end
    else if (ce)
    begin
      ir_sh_r <= ir_sh_nxt;
      ir_r <= ir_nxt;
      dr_sh_r <= dr_sh_nxt;
      div_r <= div_nxt;
      div_upd_r <= div_upd_nxt;
      tdo_r <= tdo_nxt;
      oe_r <= oe_nxt;
      sec_r <= sec_nxt;
      cap_r <= cap_nxt;
      rec_r <= rec_nxt;
      start_r <= start_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign tdo = tdo_r;
  assign tdo_oe = oe_r;
  assign secured = sec_r;
  // debug gated while secured or erasing
  assign dbg_enable = ~sec_r & (rec_r == fslr_pkg::FSLR_IDLE);
  assign dbg_flash_grant = dbg_flash_req & dbg_enable;
  assign debug_sel = dbg_enable & (ir_r == fslr_pkg::IR_DEBUG);
  assign boundary_scan_sel = (ir_r != fslr_pkg::IR_RECOVER);
  assign erase_div = div_r;
  assign erase_start = start_r;
  assign erase_busy = (rec_r == fslr_pkg::FSLR_ERASE);

  property p_start;
    @(posedge ref_clk) disable iff (!nrst)
    erase_start |-> erase_busy && !$past(erase_busy);
  endproperty
  a_start: assert property (p_start) else $error("start");
  property p_block;
    @(posedge ref_clk) disable iff (!nrst)
    (secured || erase_busy) |-> !dbg_flash_grant;
  endproperty
  a_block: assert property (p_block) else $error("grant");
  property p_hold;
    @(posedge ref_clk) disable iff (!nrst)
    (rec_r == fslr_pkg::FSLR_DONE) |=> (rec_r == fslr_pkg::FSLR_DONE && !dbg_enable);
  endproperty
  a_hold: assert property (p_hold) else $error("release");
  property p_lock;
    @(posedge ref_clk) disable iff (!nrst)
    (ce && !cap_r) |=> (secured == ($past(sec_word) == fslr_pkg::SEC_LOCKED));
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_keep;
    @(posedge ref_clk) disable iff (!nrst)
    (erase_busy && !erase_done) |=> erase_busy;
  endproperty
  a_keep: assert property (p_keep) else $error("erase dropped");
  property p_sticky;
    @(posedge ref_clk) disable iff (!nrst)
    (ce && cap_r) |=> $stable(secured);
  endproperty
  a_sticky: assert property (p_sticky) else $error("security moved");
endmodule : fslr_top
`default_nettype wire

// File: fslr_host_model.sv
// JTAG host and flash array model facing the lockout recovery block
`timescale 1ns/1ps
`default_nettype none
module fslr_host_model #(
  parameter int ERASE_CYC = 300
) (
  input wire logic ref_clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic erase_start,
  output logic erase_done,
  output logic [15:0] sec_word
);
  int busy_cnt = 0;
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    erase_done = 1'b0;
    sec_word = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////
  // four test signals
  // Half period of six clocks so tdo has settled before sampling
  task automatic pulse(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (6) @(posedge ref_clk);
    q = tdo;
    tck <= 1'b1;
    repeat (6) @(posedge ref_clk);
    tck <= 1'b0;
  endtask : pulse
  task automatic idle(input int n);
    logic q;
    repeat (n) pulse(1'b0, 1'b0, q);
  endtask : idle
  // Through reset state and back to idle
  task automatic leave;
    logic q;
    repeat (3) pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
  endtask : leave
  task automatic set_word(input logic [15:0] w);
    sec_word <= w;
  endtask : set_word
  task automatic scan(input logic ir, input int n, input logic [31:0] v, output logic [31:0] o);
    logic q;
    o = 32'h0000_0000;
    pulse(1'b1, 1'b0, q);
    if (ir)
      pulse(1'b1, 1'b0, q);
    repeat (2) pulse(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      pulse(i == n - 1, v[i], q);
      o[i] = q;
    end
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
  endtask : scan
  ////////////////////////////////////////////////////////////////
  // Erase takes a fixed time, then the array reads blank
  always @(posedge ref_clk)
  begin
    if (erase_start === 1'b1)
      busy_cnt <= ERASE_CYC;
    else if (busy_cnt > 0)
      busy_cnt <= busy_cnt - 1;
    erase_done <= (busy_cnt == 1);
    if (busy_cnt == 1)
      sec_word <= 16'hffff;
  end
endmodule : fslr_host_model
`default_nettype wire

// File: tb_flash_security_lockout_recovery.sv
// Self-checking bench for the flash security lockout recovery block
`timescale 1ns/1ps
`default_nettype none
module tb_flash_security_lockout_recovery;
  localparam logic [31:0] ID = 32'h5a3c_0001; // Arbitrary value
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic dbg_flash_req = 1'b0;
  logic boundary_scan_tdo = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, erase_done, dbg_flash_grant, dbg_enable, secured;
  logic erase_start, erase_busy, boundary_scan_sel, debug_sel;
  logic [15:0] sec_word;
  logic [6:0] erase_div;
  logic [31:0] o;
  int err_count = 0;
  int checked = 0;
  int starts = 0;
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  fslr_top #(.ID_CODE(ID)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .sec_word(sec_word),
    .dbg_flash_req(dbg_flash_req), .dbg_flash_grant(dbg_flash_grant),
    .dbg_enable(dbg_enable), .secured(secured), .erase_div(erase_div),
    .erase_start(erase_start), .erase_done(erase_done), .erase_busy(erase_busy),
    .boundary_scan_tdo(boundary_scan_tdo), .boundary_scan_sel(boundary_scan_sel),
    .debug_sel(debug_sel));
  fslr_host_model i_host (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .erase_start(erase_start), .erase_done(erase_done), .sec_word(sec_word));
  always @(posedge ref_clk)
  begin
    dbg_flash_req <= 1'($urandom);
    boundary_scan_tdo <= 1'($urandom);
    if (erase_start === 1'b1)
      starts <= starts + 1;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  function automatic logic locked(input logic [15:0] w);
    return w == fslr_pkg::SEC_LOCKED;
  endfunction : locked
  task automatic do_reset(input logic [15:0] w);
    i_host.set_word(w);
    nrst <= 1'b0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    i_host.idle(1);
  endtask : do_reset
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////
  initial
  begin
    logic [15:0] w;
    logic [6:0] d;
    void'($urandom(32'h04e5));
    // Locked, open, locked again after open, random words
    for (int i = 0; i < 6; i++)
    begin
      w = (i == 1) ? fslr_pkg::SEC_OPEN : (i % 2 == 0) ? fslr_pkg::SEC_LOCKED : 16'($urandom);
      do_reset(w);
      @(posedge ref_clk);
      check("secured", secured, locked(w));
      check("grant", dbg_flash_grant, dbg_flash_req & !locked(w));
      check("dbg_enable", dbg_enable, !locked(w));
      i_host.scan(1'b0, 32, 32'($urandom), o);
      check("idcode", o, ID);
      check("tdo_oe", tdo_oe, 1'b0);
      i_host.scan(1'b1, 4, 32'(fslr_pkg::IR_DEBUG), o);
      check("debug_sel", debug_sel, !locked(w));
      check("bs_sel_dbg", boundary_scan_sel, 1'b1);
      $display("test reset word %h done", w);
    end
    // Instruction alone, no divider update: no erase
    do_reset(fslr_pkg::SEC_LOCKED);
    i_host.scan(1'b1, 4, 32'(fslr_pkg::IR_RECOVER), o);
    i_host.idle(3);
    check("start_no_div", starts, 0);
    check("bs_sel", boundary_scan_sel, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      d = (k == 0) ? 7'h7f : 7'($urandom);
      // A finished recovery waits for reset, so each pass starts locked
      do_reset(fslr_pkg::SEC_LOCKED);
      i_host.scan(1'b1, 4, 32'(fslr_pkg::IR_RECOVER), o);
      i_host.scan(1'b0, fslr_pkg::DIV_W, 32'(d), o);
      check("divider", erase_div, d);
      check("starts", starts, k + 1);
      if (k == 1)
        i_host.leave();
      check("busy", erase_busy, 1'b1);
      check("dbg_off", dbg_enable, 1'b0);
      // host holds idle until the erase ends
      for (int t = 0; t < 1000 && erase_busy !== 1'b0; t++)
        @(posedge ref_clk);
      if (erase_busy !== 1'b0)
      begin
        err_count++;
        conclude();
      end
      check("secured_kept", secured, 1'b1);
      $display("test recovery %0d done", k);
    end
    do_reset(i_host.sec_word);
    @(posedge ref_clk);
    check("unsecured", secured, 1'b0);
    check("grant_open", dbg_flash_grant, dbg_flash_req);
    $display("test unlock done");
    // Clock enable low after release: capture waits, part stays secured
    i_host.set_word(fslr_pkg::SEC_OPEN);
    nrst <= 1'b0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    ce <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check("ce_frozen", secured, 1'b1);
    ce <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("ce_resume", secured, 1'b0);
    $display("test clock enable done");
    conclude();
  end
endmodule : tb_flash_security_lockout_recovery
`default_nettype wire
